/* design/twbc_top.sv */
// Purpose: Two-wire bus control bits: stop request, write collision,
//          interface enable with pin takeover, interrupt gating.
// Assumes: AXI4-Lite register access; scl and sda arrive asynchronously.
// Notes:   Open-drain pins: output is always low, enable pulls the line.
`timescale 1ns/1ps
`include "twbc_map.svh"

module twbc_top (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output twbc_pkg::twbc_pins_t    pins,
    output logic                    filters_on,
    output logic                    bus_irq,
    output logic                    irq
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    always_ff @(posedge aclk) begin
        scl_sync <= {scl_sync[0], scl_i};
        sda_sync <= {sda_sync[0], sda_i};
    end
    wire scl_high = scl_sync[1];
    wire sda_high = sda_sync[1];

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        wr_lane0;
    logic        wr_fire;
    wire next_wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid
                        & ~wr_fire;
    wire next_rd_take = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    wire wr_ctrl = wr_fire & wr_lane0 & (wr_addr == `TWBC_CTRL_OFS);
    wire wr_dat  = wr_fire & wr_lane0 & (wr_addr == `TWBC_DATA_OFS);
    wire wr_mask = wr_fire & wr_lane0 & (wr_addr == `TWBC_MASK_OFS);
    wire wr_gie  = wr_fire & wr_lane0 & (wr_addr == `TWBC_GIE_OFS);
    wire wr_hit  = (wr_addr == `TWBC_CTRL_OFS) | (wr_addr == `TWBC_DATA_OFS)
                 | (wr_addr == `TWBC_MASK_OFS) | (wr_addr == `TWBC_GIE_OFS)
                 | (wr_addr == `TWBC_EVT_OFS);
    wire rd_hit  = (s_axi_araddr == `TWBC_CTRL_OFS) | (s_axi_araddr == `TWBC_DATA_OFS)
                 | (s_axi_araddr == `TWBC_EVT_OFS) | (s_axi_araddr == `TWBC_MASK_OFS)
                 | (s_axi_araddr == `TWBC_GIE_OFS);
    wire rd_evt  = next_rd_take & (s_axi_araddr == `TWBC_EVT_OFS);

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic        irq_en;
    logic        master;
    logic        enable;
    logic        coll;
    logic        stop_req;
    logic        done;
    logic        gie;
    logic [7:0]  data_reg;
    logic [`TWBC_EVT_W-1:0] evt;
    logic [`TWBC_EVT_W-1:0] mask;
    twbc_pkg::twbc_state_t state;
    logic [`TWBC_CNT_W-1:0] cnt;

    wire [7:0] ctrl_rd = {done, 2'h0, stop_req, coll, enable, master, irq_en};
    wire next_enable = wr_ctrl ? wr_data[`TWBC_CTRL_EN] : enable;
    wire sto_wr      = wr_ctrl & wr_data[`TWBC_CTRL_STO];
    wire cnt_zero    = (cnt == `TWBC_CNT_W'(0));
    wire slave_rec   = sto_wr & ~wr_data[`TWBC_CTRL_MASTER] & next_enable;
    wire stop_fin    = (state == twbc_pkg::TWBC_SDA_HIGH) & cnt_zero & sda_high;
    wire done_set    = stop_fin | slave_rec;

    // ------------------------------------------------------------
    // Stop sequence
    // ------------------------------------------------------------
    twbc_pkg::twbc_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            twbc_pkg::TWBC_IDLE: begin
                if (sto_wr & wr_data[`TWBC_CTRL_MASTER] & next_enable)
                    next_state = twbc_pkg::TWBC_SDA_LOW;
            end
            twbc_pkg::TWBC_SDA_LOW: begin
                if (cnt_zero)
                    next_state = twbc_pkg::TWBC_SCL_HIGH;
            end
            twbc_pkg::TWBC_SCL_HIGH: begin
                if (cnt_zero & scl_high)
                    next_state = twbc_pkg::TWBC_SDA_HIGH;
            end
            twbc_pkg::TWBC_SDA_HIGH: begin
                if (stop_fin)
                    next_state = twbc_pkg::TWBC_IDLE;
            end
            default: next_state = twbc_pkg::TWBC_IDLE;
        endcase
        if (~next_enable)
            next_state = twbc_pkg::TWBC_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= twbc_pkg::TWBC_IDLE;
            cnt   <= `TWBC_CNT_W'(0);
        end else begin
            state <= next_state;
            if (next_state != state)
                cnt <= `TWBC_CNT_W'(`TWBC_STOP_CYC - 1);
            else if (!cnt_zero)
                cnt <= cnt - `TWBC_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Control and data registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en   <= 1'b0;
            master   <= 1'b0;
            enable   <= 1'b0;
            stop_req <= 1'b0;
            done     <= 1'b0;
            gie      <= 1'b0;
            mask     <= `TWBC_EVT_W'(0);
            data_reg <= 8'h00;
        end else begin
            enable <= next_enable;
            if (wr_ctrl) begin
                irq_en <= wr_data[`TWBC_CTRL_IE];
                master <= wr_data[`TWBC_CTRL_MASTER];
            end
            if (~next_enable | stop_fin | slave_rec)
                stop_req <= 1'b0;
            else if (sto_wr)
                stop_req <= 1'b1;
            if (done_set)
                done <= 1'b1;
            else if (wr_ctrl & wr_data[`TWBC_CTRL_DONE])
                done <= 1'b0;
            if (wr_gie)
                gie <= wr_data[`TWBC_GIE_BIT];
            if (wr_mask)
                mask <= wr_data[`TWBC_EVT_W-1:0];
            if (wr_dat & done)
                data_reg <= wr_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // Write collision flag
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            coll <= 1'b0;
        else if (wr_dat & ~done)
            coll <= 1'b1;
        else if (wr_dat)
            coll <= 1'b0;
    end

    // ------------------------------------------------------------
    // Events and interrupts
    // ------------------------------------------------------------
    wire [`TWBC_EVT_W-1:0] evt_set = {stop_fin, wr_dat & ~done, done_set & ~done};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt     <= `TWBC_EVT_W'(0);
            irq     <= 1'b0;
            bus_irq <= 1'b0;
        end else begin
            evt     <= (rd_evt ? `TWBC_EVT_W'(0) : evt) | evt_set;
            irq     <= |(evt & mask);
            bus_irq <= done & irq_en & gie;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // take pins only during the stop sequence, and only while enabled
    wire next_sda_oe = next_enable & ((next_state == twbc_pkg::TWBC_SDA_LOW)
                     | (next_state == twbc_pkg::TWBC_SCL_HIGH));
    wire next_scl_oe = next_enable & (next_state == twbc_pkg::TWBC_SDA_LOW);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins       <= '0;
            filters_on <= 1'b0;
        end else begin
            pins.scl_o  <= 1'b0;
            pins.sda_o  <= 1'b0;
            pins.scl_oe <= next_scl_oe;
            pins.sda_oe <= next_sda_oe;
            filters_on  <= next_enable;
        end
    end

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TWBC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `TWBC_RESP_OKAY;
            s_axi_rdata   <= 32'h0;
            wr_fire       <= 1'b0;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0;
            wr_lane0      <= 1'b0;
        end else begin
            s_axi_awready <= next_wr_take;
            s_axi_wready  <= next_wr_take;
            wr_fire       <= next_wr_take;
            if (next_wr_take) begin
                wr_addr  <= s_axi_awaddr;
                wr_data  <= s_axi_wdata;
                wr_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `TWBC_RESP_OKAY : `TWBC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= next_rd_take;
            if (next_rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_hit ? `TWBC_RESP_OKAY : `TWBC_RESP_SLVERR;
                case (s_axi_araddr)
                    `TWBC_CTRL_OFS: s_axi_rdata <= {24'h0, ctrl_rd};
                    `TWBC_DATA_OFS: s_axi_rdata <= {24'h0, data_reg};
                    `TWBC_EVT_OFS:  s_axi_rdata <= {29'h0, evt | evt_set};
                    `TWBC_MASK_OFS: s_axi_rdata <= {29'h0, mask};
                    `TWBC_GIE_OFS:  s_axi_rdata <= {31'h0, gie};
                    default:        s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    stop_starts_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (sto_wr & wr_data[`TWBC_CTRL_MASTER] & next_enable & state == twbc_pkg::TWBC_IDLE)
        |=> pins.sda_oe & pins.scl_oe & stop_req)
        else $error("stop request as master did not start a stop");
    stop_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_fin & ~sto_wr |=> ~stop_req & ~pins.sda_oe & (state == twbc_pkg::TWBC_IDLE))
        else $error("stop request not cleared after stop");
    slave_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        slave_rec & state == twbc_pkg::TWBC_IDLE |=> ~pins.sda_oe & ~pins.scl_oe & ~stop_req)
        else $error("slave recovery did not release lines");
    coll_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_dat & ~done |=> coll ##1 evt[`TWBC_EVT_WC] | $past(rd_evt))
        else $error("write collision not flagged");
    coll_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_dat & done |=> ~coll & (data_reg == $past(wr_data[7:0])))
        else $error("clean data write did not clear collision");
    pins_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pins.sda_oe | pins.scl_oe) |-> enable & filters_on)
        else $error("pins driven while interface disabled");
    abort_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl & ~wr_data[`TWBC_CTRL_EN]
        |=> (state == twbc_pkg::TWBC_IDLE) & ~pins.sda_oe & ~pins.scl_oe & ~stop_req)
        else $error("disable did not abort the interface");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 bus_irq == $past(done & irq_en & gie))
        else $error("interrupt request does not follow done flag");

endmodule // twbc_top

/* inc/twbc_map.svh */
// Purpose: Register offsets, field positions, response codes and timing counts.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word.
// Notes:   Included by its bare name.
`ifndef TWBC_MAP_SVH
`define TWBC_MAP_SVH

`define TWBC_CTRL_OFS       8'h00
`define TWBC_DATA_OFS       8'h04
`define TWBC_EVT_OFS        8'h08
`define TWBC_MASK_OFS       8'h0c
`define TWBC_GIE_OFS        8'h10

`define TWBC_CTRL_IE        0
`define TWBC_CTRL_MASTER    1
`define TWBC_CTRL_EN        2
`define TWBC_CTRL_WC        3
`define TWBC_CTRL_STO       4
`define TWBC_CTRL_DONE      7
`define TWBC_GIE_BIT        0

`define TWBC_EVT_DONE       0
`define TWBC_EVT_WC         1
`define TWBC_EVT_STOP       2
`define TWBC_EVT_W          3

`define TWBC_RESP_OKAY      2'h0
`define TWBC_RESP_SLVERR    2'h2

`define TWBC_CLK_NS         50
`define TWBC_STOP_HALF_NS   5000
`define TWBC_STOP_CYC       ((`TWBC_STOP_HALF_NS + `TWBC_CLK_NS - 1) / `TWBC_CLK_NS)
`define TWBC_CNT_W          8

`endif

/* inc/twbc_pkg.sv */
// Purpose: Types shared by the two-wire bus control block.
// Assumes: Constants live in twbc_map.svh.
// Notes:   Gray-coded stop sequence states.
package twbc_pkg;

    typedef enum logic [1:0] {
        TWBC_IDLE     = 2'h0,
        TWBC_SDA_LOW  = 2'h1,
        TWBC_SCL_HIGH = 2'h3,
        TWBC_SDA_HIGH = 2'h2
    } twbc_state_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } twbc_pins_t;

endpackage

/* tb/twbc_bus_model.sv */
// Purpose: Far side of the two-wire bus: pull-ups and a slave that stretches SCL.
// Assumes: Open-drain lines; an enable high pulls its line low.
// Notes:   Stretch is counted on the slow link clock.
`timescale 1ns/1ps

module twbc_bus_model (
    input  wire logic       link_clk,
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic [7:0] stretch,
    output logic            scl,
    output logic            sda
);
    logic [7:0] hold = 8'h00;

    // Holds SCL low for a while after the master lets it go.
    always @(posedge link_clk) begin
        if (scl_oe)
            hold <= stretch;
        else if (hold != 8'h00)
            hold <= hold - 8'h01;
    end

    // Released lines float up to the pull-up level.
    assign scl = ~(scl_oe | (hold != 8'h00));
    assign sda = ~sda_oe;
endmodule // twbc_bus_model

/* tb/two_wire_bus_control_bits_bench.sv */
// Purpose: Self-checking bench for the two-wire bus control bits.
// Assumes: Register map of twbc_map.svh.
// Notes:   Data comes from an LFSR seeded with 32'hc33e.
`timescale 1ns/1ps
`include "twbc_map.svh"

module two_wire_bus_control_bits_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, link_clk = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, stretch = 8'h00;
    logic [3:0]  strb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, rd, lfsr = 32'hc33e;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, filters_on, bus_irq, irq, scl, sda;
    twbc_pkg::twbc_pins_t pins;
    int          num_errors = 0, cmp_count = 0, cyc = 0, run = 0, last_run = 0, n;

    initial forever #25 aclk = ~aclk;
    initial forever #200 link_clk = ~link_clk;

    twbc_top twbc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
        .sda_i(sda), .pins(pins), .filters_on(filters_on), .bus_irq(bus_irq), .irq(irq));

    twbc_bus_model twbc_bus_model_i (.link_clk(link_clk), .scl_oe(pins.scl_oe),
        .sda_oe(pins.sda_oe), .stretch(stretch), .scl(scl), .sda(sda));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic irq_exp(input logic ie, input logic g, input logic d);
        return ie & g & d;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        chk("wready", 32'(wready), 32'h1);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arv <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Measures how long pins.scl_oe drives SCL low, slave stretch not counted, and cuts a hang short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (pins.scl_oe === 1'b1)
            run <= run + 1;
        else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("pins", 32'(pins), 32'h0);
        chk("irqs", {30'h0, bus_irq, irq}, 32'h0);
        axr(8'h20);
        chk("resp", 32'(rs), 32'h2);
        axw(8'h20, 32'h1);
        chk("bresp", 32'(rs), 32'h2);
        strb <= 4'he;
        axw(`TWBC_CTRL_OFS, 32'h4);
        strb <= 4'hf;
        axr(`TWBC_CTRL_OFS);
        chk("ctrl", rd, 32'h0);
        chk("rresp", 32'(rs), 32'h0);
        axw(`TWBC_CTRL_OFS, 32'h4);
        axw(`TWBC_MASK_OFS, 32'h7);
        axw(`TWBC_GIE_OFS, 32'h1);
        chk("filters", 32'(filters_on), 32'h1);
        axw(`TWBC_DATA_OFS, 32'(lfsr[7:0]));
        lfsr = nxt(lfsr);
        axr(`TWBC_CTRL_OFS);
        chk("wc", 32'(rd[3]), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        axr(`TWBC_EVT_OFS);
        chk("evt", rd, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq", 32'(irq), 32'h0);
        // Slave recovery: lines stay released, no STOP is sent.
        axw(`TWBC_CTRL_OFS, 32'h14);
        n = 0;
        do begin
            axr(`TWBC_CTRL_OFS);
            n++;
        end while (rd[7] !== 1'b1 && n < 50);
        chk("ctrl", rd, 32'h8c);
        chk("pins", 32'(pins), 32'h0);
        for (int i = 0; i < 4; i++) begin
            axw(`TWBC_CTRL_OFS, 32'(4 + i[0]));
            axw(`TWBC_GIE_OFS, 32'(i[1]));
            repeat (2) @(posedge aclk);
            chk("bus_irq", 32'(bus_irq), 32'(irq_exp(i[0], i[1], 1'b1)));
        end
        axw(`TWBC_DATA_OFS, 32'(lfsr[7:0]));
        lfsr = nxt(lfsr);
        axr(`TWBC_CTRL_OFS);
        chk("wc", 32'(rd[3]), 32'h0);
        axw(`TWBC_CTRL_OFS, 32'h85);
        repeat (2) @(posedge aclk);
        chk("bus_irq", 32'(bus_irq), 32'(irq_exp(1'b1, 1'b1, 1'b0)));
        axr(`TWBC_EVT_OFS);
        axw(`TWBC_MASK_OFS, 32'h0);
        axw(`TWBC_DATA_OFS, 32'(lfsr[7:0]));
        repeat (2) @(posedge aclk);
        chk("irq", 32'(irq), 32'h0);
        axr(`TWBC_EVT_OFS);
        chk("evt", rd, 32'h2);
        for (int k = 0; k < 2; k++) begin
            stretch <= 8'(k * (lfsr[3:0] + 1));
            lfsr = nxt(lfsr);
            axw(`TWBC_CTRL_OFS, 32'h16);
            while (pins.scl_oe !== 1'b1) @(posedge aclk);
            chk("sda_oe", 32'(pins.sda_oe), 32'h1);
            while (pins.scl_oe === 1'b1) @(posedge aclk);
            chk("sda_oe", 32'(pins.sda_oe), 32'h1);
            while (pins.sda_oe === 1'b1) @(posedge aclk);
            chk("scl", 32'(scl), 32'h1);
            chk("phase", 32'(last_run), 32'(`TWBC_STOP_CYC));
            n = 0;
            do begin
                axr(`TWBC_CTRL_OFS);
                n++;
            end while (rd[4] !== 1'b0 && n < 200);
            chk("ctrl", rd, 32'h8e);
            axw(`TWBC_CTRL_OFS, 32'h86);
        end
        axr(`TWBC_EVT_OFS);
        chk("evt", rd, 32'h5);
        axw(`TWBC_CTRL_OFS, 32'h16);
        repeat (20) @(posedge aclk);
        chk("sda_oe", 32'(pins.sda_oe), 32'h1);
        axw(`TWBC_CTRL_OFS, 32'h0);
        repeat (2) @(posedge aclk);
        chk("pins", 32'(pins), 32'h0);
        chk("filters", 32'(filters_on), 32'h0);
        axr(`TWBC_CTRL_OFS);
        chk("ctrl", rd, 32'h8);
        // A second reset in mid-run must clear the sticky collision flag.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(`TWBC_CTRL_OFS);
        chk("ctrl", rd, 32'h0);
        close_out();
    end
endmodule // two_wire_bus_control_bits_bench
